// file: hw/pecpcs_map.svh
// Register map constants for the error counters and PCS configuration bank.
// Assumes inclusion by the package and the design module only.
`ifndef PECPCS_MAP_SVH
`define PECPCS_MAP_SVH

// ==========================================================================
// Offsets (register index, byte address is four times index)
`define PECPCS_FCC_IDX      8'h14
`define PECPCS_REC_IDX      8'h15
`define PECPCS_PCS_IDX      8'h16
`define PECPCS_IRQ_STS_IDX  8'h1A
`define PECPCS_IRQ_MSK_IDX  8'h1B

// ==========================================================================
// Configuration fields
`define PECPCS_CFG_BLK_BIT  12
`define PECPCS_CFG_FREE_BIT 11
`define PECPCS_CFG_TQ_BIT   10
`define PECPCS_CFG_SDF_BIT  9
`define PECPCS_CFG_SDA_BIT  8
`define PECPCS_CFG_F100_BIT 5
`define PECPCS_CFG_NRZI_BIT 2
`define PECPCS_CFG_SCR_BIT  1
`define PECPCS_CFG_DSC_BIT  0
`define PECPCS_CFG_WMASK    16'h1F27
`define PECPCS_CFG_RESET    16'h0100

// ==========================================================================
// Counters and interrupt status
`define PECPCS_CNT_MAX      8'hFF
`define PECPCS_IRQ_FC_BIT   0
`define PECPCS_IRQ_RE_BIT   1
`define PECPCS_IRQ_FCS_BIT  2
`define PECPCS_IRQ_RES_BIT  3
`define PECPCS_IRQ_W        4

`endif

// file: hw/pecpcs_pkg.sv
// Types shared by the error counter and PCS configuration bank.
// Assumes the map header sits beside it.
`include "pecpcs_map.svh"

package pecpcs_pkg;

  // ========================================================================
  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pecpcs_req_s;

  // Receive-side events from the PCS datapath
  typedef struct packed {
    logic falseCarrier;
    logic carrier;
    logic symbolError;
    logic collision;
  } pecpcs_evt_s;

  // Control outputs to the PCS datapath
  typedef struct packed {
    logic blockCodeSkip;
    logic freeRxClock;
    logic silentTransmitOn;
    logic signalDetectOverride;
    logic signalDetectAlgorithmSel;
    logic forceGoodLink;
    logic nrziSkip;
    logic txWhiteningSkip;
    logic rxDewhiteningSkip;
  } pecpcs_ctl_s;

  // Complete state of the block
  typedef struct packed {
    logic [7:0]                fcCount;
    logic [7:0]                reCount;
    logic [15:0]               cfg;
    logic                      carrierSeen;
    logic                      errSeen;
    logic                      collSeen;
    logic [`PECPCS_IRQ_W-1:0] irqSts;
    logic [`PECPCS_IRQ_W-1:0] irqMsk;
    logic [15:0]               rdata;
  } pecpcs_state_s;

endpackage

// file: hw/pecpcs_bank.sv
// Error counters and 100 Mb/s PCS configuration register bank.
// Assumes events arrive synchronous to clk from the PCS datapath and
// a single-cycle strobe register port on the same clock.
`timescale 1ns/10ps
`include "pecpcs_map.svh"

module pecpcs_bank (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire pecpcs_pkg::pecpcs_req_s req,
  output logic [15:0]              rdata,
  input  wire pecpcs_pkg::pecpcs_evt_s evt,
  output pecpcs_pkg::pecpcs_ctl_s  ctl,
  output logic                     irq
);
  import pecpcs_pkg::*;

  pecpcs_state_s st_r;
  pecpcs_state_s st_nxt;

  // ========================================================================
  // Decodes
  logic rdFc;
  logic rdRe;
  logic endCarrier;
  logic reHit;
  logic [`PECPCS_IRQ_W-1:0] irqSet;

  // Access and event decodes
  always_comb begin
    rdFc       = req.rd && (req.addr == `PECPCS_FCC_IDX);
    rdRe       = req.rd && (req.addr == `PECPCS_REC_IDX);
    endCarrier = st_r.carrierSeen && !evt.carrier;
    // One step per carrier event with a symbol error, none with collision
    reHit      = endCarrier && (st_r.errSeen || evt.symbolError) &&
                 !(st_r.collSeen || evt.collision);
    irqSet     = '0;
    irqSet[`PECPCS_IRQ_FC_BIT]  = evt.falseCarrier;
    irqSet[`PECPCS_IRQ_RE_BIT]  = reHit;
    irqSet[`PECPCS_IRQ_FCS_BIT] = evt.falseCarrier &&
                                  (st_r.fcCount == `PECPCS_CNT_MAX - 8'h01);
    irqSet[`PECPCS_IRQ_RES_BIT] = reHit &&
                                  (st_r.reCount == `PECPCS_CNT_MAX - 8'h01);
  end

  // ========================================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;

    // False carrier counter: read clears, same-cycle event survives
    if (rdFc) begin
      st_nxt.fcCount = evt.falseCarrier ? 8'h01 : 8'h00;
    end else if (evt.falseCarrier && st_r.fcCount != `PECPCS_CNT_MAX) begin
      st_nxt.fcCount = st_r.fcCount + 8'h01;
    end

    // Receive error counter
    if (rdRe) begin
      st_nxt.reCount = reHit ? 8'h01 : 8'h00;
    end else if (reHit && st_r.reCount != `PECPCS_CNT_MAX) begin
      st_nxt.reCount = st_r.reCount + 8'h01;
    end

    // Carrier event tracking
    st_nxt.carrierSeen = evt.carrier;
    if (evt.carrier) begin
      st_nxt.errSeen  = (st_r.carrierSeen && st_r.errSeen) || evt.symbolError;
      st_nxt.collSeen = (st_r.carrierSeen && st_r.collSeen) || evt.collision;
    end else begin
      st_nxt.errSeen  = 1'b0;
      st_nxt.collSeen = 1'b0;
    end

    // Configuration and interrupt writes
    if (req.wr) begin
      unique case (req.addr)
        `PECPCS_PCS_IDX: begin
          st_nxt.cfg = req.wdata & `PECPCS_CFG_WMASK;
        end
        `PECPCS_IRQ_STS_IDX: begin
          st_nxt.irqSts = st_r.irqSts & ~req.wdata[`PECPCS_IRQ_W-1:0];
        end
        `PECPCS_IRQ_MSK_IDX: begin
          st_nxt.irqMsk = req.wdata[`PECPCS_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Set wins over clear
    st_nxt.irqSts = st_nxt.irqSts | irqSet;

    // Read data, valid the cycle after the strobe
    st_nxt.rdata = 16'h0000;
    if (req.rd) begin
      unique case (req.addr)
        `PECPCS_FCC_IDX:     st_nxt.rdata = {8'h00, st_r.fcCount};
        `PECPCS_REC_IDX:     st_nxt.rdata = {8'h00, st_r.reCount};
        `PECPCS_PCS_IDX:     st_nxt.rdata = st_r.cfg & `PECPCS_CFG_WMASK;
        `PECPCS_IRQ_STS_IDX: st_nxt.rdata = {12'h000, st_r.irqSts};
        `PECPCS_IRQ_MSK_IDX: st_nxt.rdata = {12'h000, st_r.irqMsk};
        default:             st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r        <= '0;
      st_r.cfg    <= `PECPCS_CFG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign rdata = st_r.rdata;
  assign irq   = |(st_r.irqSts & st_r.irqMsk);

  // Control bits to the PCS datapath
  always_comb begin
    ctl.blockCodeSkip            = st_r.cfg[`PECPCS_CFG_BLK_BIT];
    ctl.freeRxClock              = st_r.cfg[`PECPCS_CFG_FREE_BIT];
    ctl.silentTransmitOn         = st_r.cfg[`PECPCS_CFG_TQ_BIT];
    ctl.signalDetectOverride     = st_r.cfg[`PECPCS_CFG_SDF_BIT];
    ctl.signalDetectAlgorithmSel = st_r.cfg[`PECPCS_CFG_SDA_BIT];
    ctl.forceGoodLink            = st_r.cfg[`PECPCS_CFG_F100_BIT];
    ctl.nrziSkip                 = st_r.cfg[`PECPCS_CFG_NRZI_BIT];
    ctl.txWhiteningSkip          = st_r.cfg[`PECPCS_CFG_SCR_BIT];
    ctl.rxDewhiteningSkip        = st_r.cfg[`PECPCS_CFG_DSC_BIT];
  end

endmodule

// file: tb/pecpcs_bank_assertions.sv
// Checker of read answers and configuration outputs of the bank.
// Assumes it is bound onto the bank and sees only its ports.
`timescale 1ns/10ps
module pecpcs_chk (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire pecpcs_pkg::pecpcs_req_s req,
  input wire logic [15:0]             rdata,
  input wire pecpcs_pkg::pecpcs_evt_s evt,
  input wire pecpcs_pkg::pecpcs_ctl_s ctl,
  input wire logic                    irq
);
  import pecpcs_pkg::*;
  // ========
  // Clocking and helpers
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  function automatic logic [15:0] cw(input pecpcs_ctl_s c);
    return {3'h0, c[8:4], 2'h0, c[3], 2'h0, c[2:0]};
  endfunction
  sequence rdA(logic [7:0] a);
    req.rd && req.addr == a;
  endsequence
  // ========
  // Properties
  AST_IDLE: assert property (!$past(req.rd) |-> rdata == 16'h0000)
    else $error("read data outside answer cycle");
  AST_RSV_CNT: assert property (req.rd && req.addr[7:1] == 7'h0A |=> rdata[15:8] == 8'h00)
    else $error("counter upper byte not zero");
  AST_RSV_CFG: assert property (rdA(8'h16) |=> rdata[15:13] == 3'h0)
    else $error("config upper bits not zero");
  AST_CFG_RD: assert property (rdA(8'h16) |=> rdata == cw(ctl))
    else $error("config read differs from controls");
  AST_CFG_WR: assert property (req.wr && req.addr == 8'h16 |=> cw(ctl) == ($past(req.wdata) & 16'h1F27))
    else $error("controls not taken from write");
  AST_CFG_HOLD: assert property (!(req.wr && req.addr == 8'h16) |=> $stable(ctl))
    else $error("controls moved without write");
  AST_FC_CLR: assert property (rdA(8'h14) ##1 rdA(8'h14) |=> rdata == {15'h0000, $past(evt.falseCarrier, 2)})
    else $error("false carrier count not cleared by read");
  AST_UNMAP: assert property (req.rd && !(req.addr inside {8'h14, 8'h15, 8'h16, 8'h1A, 8'h1B}) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind pecpcs_bank pecpcs_chk chk_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
                                   .evt(evt), .ctl(ctl), .irq(irq));

// file: tb/pecpcs_pcs_model.sv
// Behavioural PCS receive side making carrier, error and false carrier events.
// Assumes commands come right after a clock edge, one start per idle period.
`timescale 1ns/10ps
module pecpcs_pcs_model (
  input  wire logic [7:0]         cmd,
  input  wire logic               clk,
  output pecpcs_pkg::pecpcs_evt_s evt,
  output logic                    busy
);
  // ========
  // Bits: 7 start, 6 errors, 5 collision, 4 false carrier, 3:0 length
  logic [3:0] left_r = 4'h0;
  logic       err_r  = 1'b0;
  logic       coll_r = 1'b0;
  logic       fc_r   = 1'b0;
  always_ff @(posedge clk) begin
    fc_r <= cmd[4];
    if (cmd[7]) begin
      left_r <= cmd[3:0];
      err_r  <= cmd[6];
      coll_r <= cmd[5];
    end else if (busy) begin
      left_r <= left_r - 4'h1;
    end
  end
  // Errors on alternate symbols, collision over the whole event
  assign busy = left_r != 4'h0;
  assign evt  = {fc_r, busy, busy && err_r && left_r[0], busy && coll_r};
endmodule

// file: tb/phy_error_counters_pcs_config_tb_top.sv
// Bench of the counter and configuration bank driven by a PCS event model.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
module phy_error_counters_pcs_config_tb_top;
  import pecpcs_pkg::*;
  // ========
  // Signals and instances
  logic        clk = 1'b0;
  logic        rst;
  pecpcs_req_s req;
  logic [15:0] rdata;
  pecpcs_evt_s evt;
  pecpcs_ctl_s ctl;
  logic        irq;
  logic        busy;
  logic [7:0]  cmd;
  logic        rdSeen = 1'b0;
  logic [31:0] seed;
  logic [15:0] cfgVal;
  logic [15:0] expQ[$];
  int          nErrors = 0;
  int          checkCount = 0;
  int          i;
  initial forever #2 clk = ~clk;
  pecpcs_bank dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .evt(evt),
                     .ctl(ctl), .irq(irq));
  pecpcs_pcs_model pcs_u (.cmd(cmd), .clk(clk), .evt(evt), .busy(busy));
  // ========
  // Tasks
  // Next pseudo-random word of the stimulus generator
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], ^(s & 32'h8020_0003)};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    checkCount++;
    if (got !== want) begin
      nErrors++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
  endtask
  task automatic pulses(input int n);
    req <= '0;
    cmd <= 8'h10;
    repeat (n) @(posedge clk);
    cmd <= 8'h00;
    repeat (2) @(posedge clk);
  endtask
  task automatic waitFor(input logic v, input bit onIrq, input logic [7:0] c);
    int k;
    req <= '0;
    cmd <= c;
    k = 0;
    do begin
      @(posedge clk);
      cmd <= 8'h00;
      k++;
      @(negedge clk);
    end while ((onIrq ? irq !== v : busy !== 1'b0) && k < 20);
    if (k == 20) begin
      nErrors++;
      closeOut();
    end
    if (onIrq) check({15'h0000, irq}, {15'h0000, v});
    @(posedge clk);
  endtask
  // Oldest note against each read answer
  always @(posedge clk) rdSeen <= req.rd;
  always @(negedge clk) begin
    if (rdSeen) check(rdata, expQ.size() > 0 ? expQ.pop_front() : 16'hDEAD);
  end
  // ========
  // Main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    cmd = 8'h00;
    seed = 32'h603B_9086;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'h16, 16'h0100);
    rd(8'h14, 16'h0000);
    wr(8'h30, 16'hFFFF);
    rd(8'h30, 16'h0000);
    for (i = 0; i < 6; i++) begin
      seed = nextRand(seed);
      cfgVal = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
      wr(8'h16, cfgVal);
      rd(8'h16, cfgVal & 16'h1F27);
    end
    $display("test config done");
    pulses(3);
    rd(8'h14, 16'h0003);
    pulses(1);
    rd(8'h14, 16'h0001);
    rd(8'h14, 16'h0000);
    // Event lands in the same cycle as the clearing read
    req <= '0;
    cmd <= 8'h10;
    @(posedge clk);
    cmd <= 8'h00;
    rd(8'h14, 16'h0000);
    rd(8'h14, 16'h0001);
    pulses(260);
    rd(8'h14, 16'h00FF);
    $display("test false carrier done");
    waitFor(1'b0, 1'b0, 8'hC6);
    waitFor(1'b0, 1'b0, 8'hE6);
    waitFor(1'b0, 1'b0, 8'h86);
    rd(8'h15, 16'h0001);
    for (i = 0; i < 257; i++) waitFor(1'b0, 1'b0, 8'hC2);
    rd(8'h15, 16'h00FF);
    $display("test receive error done");
    rd(8'h1A, 16'h000F);
    wr(8'h1A, 16'h000F);
    wr(8'h1B, 16'h0000);
    pulses(1);
    waitFor(1'b0, 1'b1, 8'h00);
    wr(8'h1B, 16'h0001);
    waitFor(1'b1, 1'b1, 8'h00);
    wr(8'h1A, 16'h0001);
    waitFor(1'b0, 1'b1, 8'h00);
    $display("test interrupt done");
    if (expQ.size() != 0) nErrors++;
    closeOut();
  end
endmodule
